// [hdl/dcrr_defines.vh]
// constants for the direct cache ram readout block
`ifndef DCRR_DEFINES_VH
`define DCRR_DEFINES_VH
// register byte addresses
`define DCRR_DC_READ_ADDR 32'hE001E200
`define DCRR_IC_READ_ADDR 32'hE001E204
`define DCRR_DC_LOC_ADDR 32'hE001E210
`define DCRR_IC_LOC_ADDR 32'hE001E214
// location register fields
`define DCRR_LOC_RAMSEL 0
`define DCRR_LOC_WORD_HI 5
`define DCRR_LOC_WORD_LO 1
`define DCRR_LOC_IDX_HI 14
`define DCRR_LOC_IDX_LO 5
`define DCRR_LOC_IWAY 31
`define DCRR_LOC_DWAY_HI 31
`define DCRR_LOC_DWAY_LO 30
`define DCRR_LOC_RESET 32'h00000000
`define DCRR_READ_RESET 32'h00000000
// data cache tag readout fields
`define DCRR_DT_NS 26
`define DCRR_DT_ST_HI 25
`define DCRR_DT_ST_LO 23
`define DCRR_DT_VALID 22
`define DCRR_DT_TAG_HI 21
// instruction and unified tag readout fields
`define DCRR_IT_VALID 23
`define DCRR_IT_TAG_HI 22
`define DCRR_IT_TAG_LO4K 2
// status encodings of a data cache line
`define DCRR_ST_CLEAN_TR 3'h0
`define DCRR_ST_CLEAN 3'h1
`define DCRR_ST_RSVD 3'h7
// raw ram word: 32 data bits plus check bits
`define DCRR_RAW_W 39
`endif

// [hdl/dcrr_fmt.v]
// tag and data word formatter for the direct readout path
`timescale 1ns/1ps
`include "dcrr_defines.vh"
module dcrr_fmt #(
  parameter DC_KB = 4,
  parameter IC_KB = 4,
  parameter UNIFIED = 0,
  parameter SEC_EXT = 1
) (
  input wire sel_dc_i,
  input wire is_data_i,
  input wire [`DCRR_RAW_W-1:0] raw_i,
  output reg [31:0] word_o
);
  function integer lg2;
    input integer v;
    integer n;
    begin
      n = 0;
      while ((1 << n) < v)
        n = n + 1;
      lg2 = n;
    end
  endfunction

  // lowest tag bit kept for each cache size
  localparam integer DLO = lg2(DC_KB / 4);
  localparam integer ILO = `DCRR_IT_TAG_LO4K + lg2(IC_KB / 4);
  localparam integer ULO = lg2(DC_KB);
  localparam integer XLO = UNIFIED ? ULO : ILO;

  reg [2:0] st;
  integer b;
  always @* begin
    word_o = 32'h00000000;
    st = raw_i[`DCRR_DT_ST_HI:`DCRR_DT_ST_LO];
    if (is_data_i) begin
      word_o = raw_i[31:0];
    end else if (sel_dc_i && !UNIFIED) begin
      for (b = DLO; b <= `DCRR_DT_TAG_HI; b = b + 1)
        word_o[b] = raw_i[b];
      word_o[`DCRR_DT_VALID] = raw_i[`DCRR_DT_VALID];
      if (raw_i[`DCRR_DT_VALID] && st != `DCRR_ST_RSVD)
        word_o[`DCRR_DT_ST_HI:`DCRR_DT_ST_LO] = st;
      if (SEC_EXT != 0)
        word_o[`DCRR_DT_NS] = raw_i[`DCRR_DT_NS];
    end else begin
      for (b = XLO; b <= `DCRR_IT_TAG_HI; b = b + 1)
        word_o[b] = raw_i[b];
      word_o[`DCRR_IT_VALID] = raw_i[`DCRR_IT_VALID];
    end
  end
endmodule // dcrr_fmt

// [hdl/dcrr_top.v]
// direct cache ram readout: location and read system registers
`timescale 1ns/1ps
`include "dcrr_defines.vh"
module dcrr_top #(
  parameter DC_KB = 4,
  parameter IC_KB = 4,
  parameter UNIFIED = 0,
  parameter SEC_EXT = 1,
  parameter BANK_SWIZZLE = 1
) (
  input wire mclk_i,
  input wire resetn_i,
  input wire sr_req_i,
  input wire sr_wr_i,
  input wire [31:0] sr_addr_i,
  input wire [31:0] sr_wdata_i,
  input wire sr_secure_i,
  input wire sr_priv_i,
  output wire sr_ack_o,
  output wire sr_fault_o,
  output wire [31:0] sr_rdata_o,
  input wire dc_active_i,
  input wire ic_active_i,
  output wire ram_req_o,
  output wire ram_dc_o,
  output wire ram_data_o,
  output wire [9:0] ram_index_o,
  output wire [1:0] ram_bank_o,
  output wire [4:0] ram_word_o,
  input wire ram_valid_i,
  input wire [`DCRR_RAW_W-1:0] ram_rdata_i
);

  // one-hot sequencer states
  localparam [2:0] ST_IDLE = 3'h1;
  localparam [2:0] ST_RAM = 3'h2;
  localparam [2:0] ST_RESP = 3'h4;

  // address decode, used for both taking and answering
  function [3:0] dcrr_dec;
    input [31:0] a;
    begin
      dcrr_dec = 4'h0;
      case (a)
        `DCRR_DC_LOC_ADDR: dcrr_dec = 4'h1;
        `DCRR_IC_LOC_ADDR: dcrr_dec = 4'h2;
        `DCRR_DC_READ_ADDR: dcrr_dec = 4'h4;
        `DCRR_IC_READ_ADDR: dcrr_dec = 4'h8;
        default: dcrr_dec = 4'h0;
      endcase
    end
  endfunction

  // logical way to physical bank
  function [1:0] dcrr_bank;
    input [1:0] way;
    input idx0;
    begin
      if (BANK_SWIZZLE != 0)
        dcrr_bank = way ^ {1'b0, idx0};
      else
        dcrr_bank = way;
    end
  endfunction

  // reset release through two flops
  reg rst_s1_q;
  reg rst_s2_q;
  wire rst_n;
  always @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  assign rst_n = rst_s2_q;

  reg [2:0] state_q;
  reg [2:0] state_d;
  reg [31:0] dc_loc_q;
  reg [31:0] dc_loc_d;
  reg [31:0] ic_loc_q;
  reg [31:0] ic_loc_d;
  reg [31:0] dc_rd_q;
  reg [31:0] dc_rd_d;
  reg [31:0] ic_rd_q;
  reg [31:0] ic_rd_d;
  reg [31:0] rdata_q;
  reg [31:0] rdata_d;
  reg fault_q;
  reg fault_d;
  reg tgt_dc_q;
  reg tgt_dc_d;

  wire [3:0] hit;
  wire allowed;
  wire [31:0] loc;
  wire [31:0] fmt_word;

  assign hit = dcrr_dec(sr_addr_i);

  assign allowed = sr_priv_i && (sr_secure_i || (SEC_EXT == 0));

  // the location being fetched
  assign loc = tgt_dc_q ? dc_loc_q : ic_loc_q;

  assign ram_data_o = loc[`DCRR_LOC_RAMSEL];
  assign ram_dc_o = tgt_dc_q;
  assign ram_req_o = state_q[1];

  assign ram_index_o = loc[`DCRR_LOC_IDX_HI:`DCRR_LOC_IDX_LO];

  assign ram_word_o = ram_data_o ? loc[`DCRR_LOC_WORD_HI:`DCRR_LOC_WORD_LO] : 5'h00;

  assign ram_bank_o = (tgt_dc_q && !UNIFIED) ?
    dcrr_bank(loc[`DCRR_LOC_DWAY_HI:`DCRR_LOC_DWAY_LO], loc[`DCRR_LOC_IDX_LO]) :
    dcrr_bank({1'b0, loc[`DCRR_LOC_IWAY]}, loc[`DCRR_LOC_IDX_LO]);

  dcrr_fmt #(
    .DC_KB(DC_KB),
    .IC_KB(IC_KB),
    .UNIFIED(UNIFIED),
    .SEC_EXT(SEC_EXT)
  ) u_fmt (
    .sel_dc_i(tgt_dc_q),
    .is_data_i(ram_data_o),
    .raw_i(ram_rdata_i),
    .word_o(fmt_word)
  );

  // answer stands for one cycle only, in the response state
  assign sr_ack_o = state_q[2];
  assign sr_fault_o = fault_q;
  assign sr_rdata_o = rdata_q;

  // a request is taken only while the sequencer idles
  wire take;
  // location write from an allowed requester
  wire loc_wr;
  // location write that must go out to the ram
  wire fetch_go;
  // allowed read of any place in the map
  wire reg_rd;
  // ram answer during a fetch
  wire ram_done;

  assign take = state_q[0] && sr_req_i;
  assign loc_wr = take && allowed && sr_wr_i && (hit[0] || hit[1]);
  // an inactive cache is not touched; its read register is cleared instead
  assign fetch_go = loc_wr && (hit[0] ? dc_active_i : ic_active_i);
  assign reg_rd = take && allowed && !sr_wr_i;
  assign ram_done = state_q[1] && ram_valid_i;

  // sequencer next state
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (fetch_go) begin
          state_d = ST_RAM;
        end else if (sr_req_i) begin
          state_d = ST_RESP;
        end
      end
      ST_RAM: begin
        // the ram request stands until the ram answers, however slow
        if (ram_valid_i) begin
          state_d = ST_RESP;
        end
      end
      ST_RESP: begin
        // one answer cycle, so a held request is not taken twice back to back
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // location registers and fetch target
  always @* begin
    dc_loc_d = dc_loc_q;
    ic_loc_d = ic_loc_q;
    tgt_dc_d = tgt_dc_q;
    // the target follows the last location written, even to an inactive cache
    if (loc_wr) begin
      tgt_dc_d = hit[0];
      if (hit[0]) begin
        dc_loc_d = sr_wdata_i;
      end else begin
        ic_loc_d = sr_wdata_i;
      end
    end
  end

  always @* begin
    dc_rd_d = dc_rd_q;
    ic_rd_d = ic_rd_q;
    if (ram_done) begin
      if (tgt_dc_q) begin
        dc_rd_d = fmt_word;
      end else begin
        ic_rd_d = fmt_word;
      end
    // nothing fetched, so a stale word cannot pass for the new location
    end else if (loc_wr && !fetch_go) begin
      if (hit[0]) begin
        dc_rd_d = 32'h00000000;
      end else begin
        ic_rd_d = 32'h00000000;
      end
    end
  end

  // answer data and fault, held until the next take
  always @* begin
    rdata_d = rdata_q;
    fault_d = fault_q;
    if (take) begin
      // writes, refused and unmapped accesses read as zero
      rdata_d = 32'h00000000;
      fault_d = !sr_priv_i;
      if (reg_rd) begin
        case (hit)
          4'h1: rdata_d = dc_loc_q;
          4'h2: rdata_d = ic_loc_q;
          4'h4: rdata_d = dc_rd_q;
          4'h8: rdata_d = ic_rd_q;
          default: rdata_d = 32'h00000000;
        endcase
      end
    end
  end

  // sequencer state flop
  always @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // data cache location flop
  always @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      dc_loc_q <= `DCRR_LOC_RESET;
    end else begin
      dc_loc_q <= dc_loc_d;
    end
  end

  // instruction cache location flop
  always @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      ic_loc_q <= `DCRR_LOC_RESET;
    end else begin
      ic_loc_q <= ic_loc_d;
    end
  end

  // data cache read register flop
  always @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      dc_rd_q <= `DCRR_READ_RESET;
    end else begin
      dc_rd_q <= dc_rd_d;
    end
  end

  // instruction cache read register flop
  always @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      ic_rd_q <= `DCRR_READ_RESET;
    end else begin
      ic_rd_q <= ic_rd_d;
    end
  end

  // answer data flop
  always @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 32'h00000000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // fault flop
  always @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      fault_q <= 1'b0;
    end else begin
      fault_q <= fault_d;
    end
  end

  // fetch target flop
  always @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      tgt_dc_q <= 1'b0;
    end else begin
      tgt_dc_q <= tgt_dc_d;
    end
  end
endmodule // dcrr_top

// [test/dcrr_props.sv]
// checker for the direct cache ram readout register and ram ports
`timescale 1ns/1ps
module dcrr_props (
  input wire mclk_i,
  input wire resetn_i,
  input wire sr_req_i,
  input wire sr_wr_i,
  input wire [31:0] sr_addr_i,
  input wire [31:0] sr_wdata_i,
  input wire sr_secure_i,
  input wire sr_priv_i,
  input wire sr_ack_o,
  input wire sr_fault_o,
  input wire [31:0] sr_rdata_o,
  input wire ram_req_o,
  input wire ram_dc_o,
  input wire ram_data_o,
  input wire [9:0] ram_index_o,
  input wire [1:0] ram_bank_o,
  input wire [4:0] ram_word_o,
  input wire ram_valid_i
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  // the bench holds the location word on wdata while the ram read runs
  property p_sel; ram_req_o |-> ram_data_o == sr_wdata_i[0] && ram_index_o == sr_wdata_i[14:5];
  endproperty
  a_sel: assert property (p_sel) else $error("ram select or index wrong");
  property p_word; ram_req_o |-> ram_word_o == (ram_data_o ? sr_wdata_i[5:1] : 5'h00); endproperty
  a_word: assert property (p_word) else $error("word offset wrong");
  property p_dc; ram_req_o |-> ram_dc_o == (sr_addr_i == 32'hE001E210); endproperty
  a_dc: assert property (p_dc) else $error("cache select wrong");
  // way to bank mapping swaps on odd sets
  property p_bank; ram_req_o |-> ram_bank_o == ((ram_dc_o ? sr_wdata_i[31:30]
    : {1'b0, sr_wdata_i[31]}) ^ {1'b0, sr_wdata_i[5]}); endproperty
  a_bank: assert property (p_bank) else $error("bank mapping wrong");
  property p_rd; $rose(sr_req_i) && !sr_wr_i |=> sr_ack_o; endproperty
  a_rd: assert property (p_rd) else $error("read not answered");
  property p_done; ram_req_o && ram_valid_i |=> sr_ack_o && !ram_req_o; endproperty
  a_done: assert property (p_done) else $error("ram result not finished");
  property p_ack1; sr_ack_o |=> !sr_ack_o; endproperty
  a_ack1: assert property (p_ack1) else $error("answer longer than one cycle");
  property p_hold; ram_req_o && !ram_valid_i |=> ram_req_o; endproperty
  a_hold: assert property (p_hold) else $error("ram request dropped");
  property p_fault; sr_ack_o |-> sr_fault_o == !sr_priv_i; endproperty
  a_fault: assert property (p_fault) else $error("fault wrong");
  property p_raz; sr_ack_o && !sr_wr_i && !sr_secure_i |-> sr_rdata_o == 32'h00000000; endproperty
  a_raz: assert property (p_raz) else $error("nonsecure read not zero");
  property p_blk; sr_req_i && !(sr_secure_i && sr_priv_i) |=> !ram_req_o; endproperty
  a_blk: assert property (p_blk) else $error("blocked access reached ram");
  c_ram: cover property (ram_req_o && ram_valid_i);
  c_flt: cover property (sr_ack_o && sr_fault_o);
  c_ns: cover property (sr_ack_o && !sr_secure_i);
endmodule // dcrr_props

// [test/dcrr_tb_top.sv]
// testbench for the direct cache ram readout block
`timescale 1ns/1ps
`include "dcrr_defines.vh"
module dcrr_tb_top;
  localparam logic [31:0] il = `DCRR_IC_LOC_ADDR, ir = `DCRR_IC_READ_ADDR;
  localparam logic [31:0] dl = `DCRR_DC_LOC_ADDR, dr = `DCRR_DC_READ_ADDR;
  logic mclk_i = 1'b0, resetn_i = 1'b0, sr_req_i = 1'b0, sr_wr_i = 1'b0;
  logic sr_secure_i = 1'b1, sr_priv_i = 1'b1, dc_active_i = 1'b1, ic_active_i = 1'b1;
  logic ram_valid_i = 1'b0, flt = 1'b0;
  logic [31:0] sr_addr_i = 32'h0, sr_wdata_i = 32'h0, q, e;
  logic [38:0] raw = 39'h0;
  wire sr_ack_o, sr_fault_o, ram_req_o, ram_dc_o, ram_data_o;
  wire [31:0] sr_rdata_o;
  wire [9:0] ram_index_o;
  wire [1:0] ram_bank_o;
  wire [4:0] ram_word_o;
  // outside valid the ram data lines carry garbage so stale data cannot pass
  wire [38:0] ram_rdata_i = ram_valid_i ? raw : ~raw;
  int fail_count = 0, samples_checked = 0, rdly = 0, cnt = 0;
  always #12.5 mclk_i = ~mclk_i;
  dcrr_top dut_u (
    .mclk_i(mclk_i),
    .resetn_i(resetn_i),
    .sr_req_i(sr_req_i),
    .sr_wr_i(sr_wr_i),
    .sr_addr_i(sr_addr_i),
    .sr_wdata_i(sr_wdata_i),
    .sr_secure_i(sr_secure_i),
    .sr_priv_i(sr_priv_i),
    .sr_ack_o(sr_ack_o),
    .sr_fault_o(sr_fault_o),
    .sr_rdata_o(sr_rdata_o),
    .dc_active_i(dc_active_i),
    .ic_active_i(ic_active_i),
    .ram_req_o(ram_req_o),
    .ram_dc_o(ram_dc_o),
    .ram_data_o(ram_data_o),
    .ram_index_o(ram_index_o),
    .ram_bank_o(ram_bank_o),
    .ram_word_o(ram_word_o),
    .ram_valid_i(ram_valid_i),
    .ram_rdata_i(ram_rdata_i)
  );
  // ram answers after rdly waiting cycles, one valid pulse per request
  always @(posedge mclk_i) begin
    #1;
    ram_valid_i = ram_req_o && !ram_valid_i && cnt >= rdly;
    cnt = ram_req_o && !ram_valid_i ? cnt + 1 : 0;
  end
  task wrap_up;
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task chk(input logic [31:0] s, x);
    samples_checked++;
    if (s !== x) begin
      fail_count++;
      $display("Error %0t seen %h expected %h", $time, s, x);
    end
  endtask
  // one register access; request held one edge past the one where ack is seen, then dropped for an idle edge
  task acc(input logic w, input logic [31:0] a, d, output logic [31:0] r);
    int n;
    n = 0;
    sr_wr_i = w;
    sr_addr_i = a;
    sr_wdata_i = d;
    sr_req_i = 1'b1;
    do begin
      @(posedge mclk_i);
      #1;
      n++;
    end while (sr_ack_o !== 1'b1 && n < 50);
    if (sr_ack_o !== 1'b1) begin
      fail_count++;
      wrap_up;
    end
    r = sr_rdata_o;
    flt = sr_fault_o;
    @(posedge mclk_i);
    #1;
    sr_req_i = 1'b0;
    @(posedge mclk_i);
    #1;
  endtask
  // write a location, read it back, then read the matching read register
  task rl(input logic [31:0] la, ra, loc, x);
    acc(1'b1, la, loc, q);
    acc(1'b0, la, 32'h0, q);
    chk(q, loc);
    acc(1'b0, ra, 32'h0, q);
    chk(q, x);
  endtask
  // icache tag with every raw bit set: only valid and the 4KB tag field survive
  task t_ic_tag;
    raw = {7'h7F, 32'hFFFFFFFF};
    rdly = 0;
    rl(il, ir, 32'h800054A0, 32'h00FFFFFC);
  endtask
  // data ram words behind a slow ram; check bits never reach the read register
  task t_data_word;
    raw = {7'h55, 32'hA5C30F96};
    rdly = 3;
    rl(il, ir, 32'h0000003F, 32'hA5C30F96);
    rl(dl, dr, 32'h4000000B, 32'hA5C30F96);
    rdly = 0;
  endtask
  // every status code of a valid dcache line; the reserved one reads as zero
  task t_status;
    for (int s = 0; s < 8; s++) begin
      raw = {7'h7F, 5'h00, 1'b1, s[2:0], 1'b1, 22'h3FFFFF};
      e = {5'h00, 1'b1, s == 7 ? 3'h0 : s[2:0], 1'b1, 22'h3FFFFF};
      rl(dl, dr, 32'h80000020, e);
    end
  endtask
  // unprivileged access faults, nonsecure access is silent and has no effect
  task t_access;
    sr_priv_i = 1'b0;
    acc(1'b1, il, 32'h00000001, q);
    chk({31'h0, flt}, 32'h00000001);
    sr_priv_i = 1'b1;
    sr_secure_i = 1'b0;
    acc(1'b1, il, 32'h00000001, q);
    acc(1'b0, dr, 32'h0, q);
    chk(q, 32'h00000000);
    chk({31'h0, flt}, 32'h00000000);
    sr_secure_i = 1'b1;
    acc(1'b0, il, 32'h0, q);
    chk(q, 32'h0000003F);
  endtask
  // read register ignores writes, unmapped place reads zero
  task t_map;
    acc(1'b1, ir, 32'h00000001, q);
    acc(1'b0, ir, 32'h0, q);
    chk(q, 32'hA5C30F96);
    acc(1'b0, 32'hE001E220, 32'h0, q);
    chk(q, 32'h00000000);
  endtask
  // powered-down caches are not read and their read registers clear
  task t_inactive;
    ic_active_i = 1'b0;
    dc_active_i = 1'b0;
    acc(1'b1, il, 32'h800054A0, q);
    acc(1'b0, ir, 32'h0, q);
    chk(q, 32'h00000000);
    acc(1'b1, dl, 32'h80000020, q);
    acc(1'b0, dr, 32'h0, q);
    chk(q, 32'h00000000);
    ic_active_i = 1'b1;
    dc_active_i = 1'b1;
  endtask
  initial begin
    repeat (5) @(posedge mclk_i);
    #1 resetn_i = 1'b1;
    repeat (3) @(posedge mclk_i);
    #1;
    t_ic_tag;
    t_data_word;
    t_status;
    t_access;
    t_map;
    t_inactive;
    wrap_up;
  end
endmodule // dcrr_tb_top
bind dcrr_top dcrr_props props_u (
  .mclk_i(mclk_i),
  .resetn_i(resetn_i),
  .sr_req_i(sr_req_i),
  .sr_wr_i(sr_wr_i),
  .sr_addr_i(sr_addr_i),
  .sr_wdata_i(sr_wdata_i),
  .sr_secure_i(sr_secure_i),
  .sr_priv_i(sr_priv_i),
  .sr_ack_o(sr_ack_o),
  .sr_fault_o(sr_fault_o),
  .sr_rdata_o(sr_rdata_o),
  .ram_req_o(ram_req_o),
  .ram_dc_o(ram_dc_o),
  .ram_data_o(ram_data_o),
  .ram_index_o(ram_index_o),
  .ram_bank_o(ram_bank_o),
  .ram_word_o(ram_word_o),
  .ram_valid_i(ram_valid_i)
);
